//--- dcls_pkg.sv
// Shared constants and types for the display clock and palette control block.
package dcls_pkg;

    // ************************************************************
    // Register indexes on the sequencer data port
    // ************************************************************
    localparam logic [7:0] DCLS_IDX_PAL  = 8'h66;
    localparam logic [7:0] DCLS_IDX_CLK1 = 8'h68;
    localparam logic [7:0] DCLS_IDX_CLK2 = 8'h69;

    // ************************************************************
    // Register layouts, most significant field first
    // ************************************************************
    typedef struct packed {
        logic [1:0] power;
        logic [1:0] target;
        logic [1:0] width;
        logic [1:0] rsvd;
    } dcls_pal_t;

    typedef struct packed {
        logic [1:0] pix_src;
        logic       refresh_hi;
        logic       char8;
        logic [1:0] pix_trim;
        logic [1:0] mem_trim;
    } dcls_clk1_t;

    typedef struct packed {
        logic       tv_pin;
        logic       test_direct;
        logic [1:0] link_sel;
        logic       refresh_int;
        logic       sleep_sync;
        logic [1:0] vr_sel;
    } dcls_clk2_t;

    localparam dcls_pal_t  DCLS_PAL_RST  = 8'h00;
    localparam dcls_clk1_t DCLS_CLK1_RST = 8'hC0;
    localparam dcls_clk2_t DCLS_CLK2_RST = 8'h80;

    // ************************************************************
    // Clock source pins, all asynchronous to the reference clock
    // ************************************************************
    typedef struct packed {
        logic ext_en_n;
        logic ext_clk;
        logic vga25;
        logic vga28;
        logic vga31;
        logic vga35;
        logic synth;
        logic pal17;
        logic ntsc14;
        logic second_video;
        logic mclk;
        logic ext32k;
    } dcls_src_t;

    // ************************************************************
    // Source encodings and multiplexer indexes
    // ************************************************************
    localparam logic [1:0] DCLS_SRC_LEGACY = 2'h0;
    localparam logic [1:0] DCLS_SRC_SYNTH  = 2'h1;
    localparam logic [1:0] DCLS_SRC_PAL    = 2'h2;
    localparam logic [2:0] DCLS_PIX_VGA25  = 3'h0;
    localparam logic [2:0] DCLS_PIX_VGA31  = 3'h2;
    localparam logic [2:0] DCLS_PIX_SYNTH  = 3'h4;
    localparam logic [2:0] DCLS_PIX_PAL    = 3'h5;
    localparam logic [2:0] DCLS_PIX_EXT    = 3'h6;
    localparam logic [2:0] DCLS_PIX_NTSC   = 3'h7;
    localparam logic [2:0] DCLS_VR_PIXEL   = 3'h4;
    localparam logic [2:0] DCLS_LINK_OFF   = 3'h4;

    // ************************************************************
    // Duty trims in nanoseconds of low time, two's complement
    // ************************************************************
    localparam logic signed [2:0] DCLS_TRIM_DEF_NS    = 3'sh0;
    localparam logic signed [2:0] DCLS_TRIM_SHORT_NS  = 3'sh7;
    localparam logic signed [2:0] DCLS_TRIM_LONG_NS   = 3'sh1;
    localparam logic signed [2:0] DCLS_TRIM_LONGER_NS = 3'sh2;

    typedef enum logic {
        DCLS_MUX_RUN  = 1'b0,
        DCLS_MUX_HOLD = 1'b1
    } dcls_mux_state_t;

endpackage : dcls_pkg

//--- dcls_sync.sv
// Two-flop synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ns
`default_nettype none
module dcls_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst_n,
    // Levels
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] s2;
        logic [W-1:0] s1;
    } dcls_sync_state_t;

    dcls_sync_state_t q;
    dcls_sync_state_t d;

    if (W < 1) begin : g_bad_width
        $error("dcls_sync needs a width of at least one");
    end

    always_comb begin
        d    = q;
        d.s1 = i_async;
        d.s2 = q.s1;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_sync = q.s2;

endmodule : dcls_sync
`default_nettype wire

//--- dcls_clk_mux.sv
// Glitch-free clock multiplexer working on sampled clock levels.
`timescale 1ns/1ns
`default_nettype none
module dcls_clk_mux
    import dcls_pkg::*;
#(
    parameter int N  = 2,
    parameter int SW = (N > 1) ? $clog2(N) : 1
) (
    // Clock and reset
    input  wire logic          i_ref_clk,
    input  wire logic          i_rst_n,
    // Sources and select
    input  wire logic [N-1:0]  i_src,
    input  wire logic [SW-1:0] i_sel,
    output logic               o_clk
);
    typedef struct packed {
        logic [SW-1:0]   cur;
        dcls_mux_state_t st;
        logic            out;
    } dcls_mux_q_t;

    dcls_mux_q_t q;
    dcls_mux_q_t d;

    if (N < 2 || SW != $clog2(N)) begin : g_bad_n
        $error("dcls_clk_mux needs two or more sources and a matching select width");
    end

    // A switch only starts while the output is low and the output stays low
    // until the new source is low, so no shortened high or low phase leaves.
    always_comb begin
        d = q;
        case (q.st)
            DCLS_MUX_RUN: begin
                d.out = i_src[q.cur];
                if (i_sel != q.cur && int'(i_sel) < N && !q.out) begin
                    d.cur = i_sel;
                    d.st  = DCLS_MUX_HOLD;
                    d.out = 1'b0;
                end
            end
            DCLS_MUX_HOLD: begin
                d.out = 1'b0;
                if (!i_src[q.cur]) begin
                    d.st = DCLS_MUX_RUN;
                end
            end
            default: begin
                d.st  = DCLS_MUX_RUN;
                d.out = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '{cur: '0, st: DCLS_MUX_RUN, out: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign o_clk = q.out;

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    a_hold_low: assert property (q.st == DCLS_MUX_HOLD |-> !o_clk)
        else $error("Clock output not held low during a switch");
    a_switch_low: assert property ($changed(q.cur) |-> $past(!o_clk) && !o_clk)
        else $error("Clock source switched while output was high");

endmodule : dcls_clk_mux
`default_nettype wire

//--- dcls_clock_control.sv
// Display clock selection, sleep sync and palette RAM control registers.
`timescale 1ns/1ns
`default_nettype none
module dcls_clock_control
    import dcls_pkg::*;
(
    // Clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_n,
    // Sequencer index and data port
    input  wire logic              i_port_index_wr,
    input  wire logic              i_port_data_wr,
    input  wire logic              i_port_data_rd,
    input  wire logic [7:0]        i_port_wdata,
    output logic      [7:0]        o_port_rdata,
    // Clock source pins
    input  wire dcls_src_t         i_src_pins,
    // Same-domain controls from the rest of the controller
    input  wire logic [1:0]        i_legacy_clk_sel,
    input  wire logic              i_synth_post_scale,
    input  wire logic              i_virtual_refresh_en,
    input  wire logic              i_lcd_or_tv,
    input  wire logic              i_sleep,
    input  wire logic              i_standby,
    input  wire logic [1:0]        i_pd_freq_sel,
    input  wire logic              i_pal_write,
    input  wire logic              i_hsync,
    input  wire logic              i_vsync,
    input  wire logic              i_blank,
    // Selected clocks
    output logic                   o_pixel_clk,
    output logic                   o_vr_clk,
    output logic                   o_panel_link_clk,
    output logic                   o_refresh_clk,
    output logic                   o_tv_blank_pin,
    // Palette RAM control
    output logic                   o_crt_ram_on,
    output logic                   o_lcd_ram_on,
    output logic                   o_crt_ram_we,
    output logic                   o_lcd_ram_we,
    output logic                   o_crt_8bit,
    output logic                   o_gamma_on,
    // Misc control
    output logic                   o_force_8dot,
    output logic signed [2:0]      o_pix_trim_ns,
    output logic signed [2:0]      o_mem_trim_ns,
    output logic                   o_test_direct,
    output logic                   o_refresh_active,
    output logic                   o_lp_rate_en,
    output logic      [1:0]        o_lp_rate_sel,
    output logic                   o_hsync,
    output logic                   o_vsync
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0]        idx;
        dcls_pal_t         pal;
        dcls_clk1_t        c1;
        dcls_clk2_t        c2;
        logic [7:0]        rdata;
        logic              synth_prev;
        logic              post_div;
        logic              prog_prev;
        logic [1:0]        tv_cnt;
        logic              mclk_prev;
        logic              mclk_half;
        logic              vr_prev;
        logic              vr_half;
        logic              crt_on;
        logic              lcd_on;
        logic              crt_we;
        logic              lcd_we;
        logic              crt_8bit;
        logic              gamma;
        logic              force_8dot;
        logic signed [2:0] pix_trim;
        logic signed [2:0] mem_trim;
        logic              test_direct;
        logic              refresh_active;
        logic              lp_rate_en;
        logic [1:0]        lp_rate_sel;
        logic              hsync;
        logic              vsync;
    } dcls_state_t;

    dcls_state_t q;
    dcls_state_t d;
    dcls_src_t   s;
    logic        prog_clk;
    logic [2:0]  pix_idx;
    logic [2:0]  vr_idx;
    logic [2:0]  link_idx;
    logic        low_power;

    function automatic logic signed [2:0] dcls_trim_ns(input logic [1:0] code);
        case (code)
            2'h0:    dcls_trim_ns = DCLS_TRIM_DEF_NS;
            2'h1:    dcls_trim_ns = DCLS_TRIM_SHORT_NS;
            2'h2:    dcls_trim_ns = DCLS_TRIM_LONG_NS;
            default: dcls_trim_ns = DCLS_TRIM_LONGER_NS;
        endcase
    endfunction : dcls_trim_ns

    // Sources are sampled by the reference clock, so each must stay well
    // below half of it; the selected clocks are sampled replicas.
    dcls_sync #(
        .W ($bits(dcls_src_t))
    ) u_src_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_async   (i_src_pins),
        .o_sync    (s)
    );

    // ************************************************************
    // Source selection
    // ************************************************************
    // Post-scaler halves the synthesizer.
    assign prog_clk  = i_synth_post_scale ? q.post_div : s.synth;
    assign low_power = i_sleep || i_standby;

    always_comb begin
        if (!s.ext_en_n) begin
            pix_idx = DCLS_PIX_EXT;
        end else begin
            case (q.c1.pix_src)
                DCLS_SRC_LEGACY: pix_idx = {1'b0, q.c1.refresh_hi, i_legacy_clk_sel[0]};
                DCLS_SRC_SYNTH:  pix_idx = DCLS_PIX_SYNTH;
                DCLS_SRC_PAL:    pix_idx = DCLS_PIX_PAL;
                default:         pix_idx = DCLS_PIX_NTSC;
            endcase
        end
        vr_idx   = i_virtual_refresh_en ? {1'b0, q.c2.vr_sel} : DCLS_VR_PIXEL;
        // Panel link only with the enable pin high.
        link_idx = s.ext_en_n ? {1'b0, q.c2.link_sel} : DCLS_LINK_OFF;
    end

    dcls_clk_mux #(.N (8)) u_pix_mux (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_src     ({s.ntsc14, s.ext_clk, s.pal17, prog_clk,
                     s.vga35, s.vga31, s.vga28, s.vga25}),
        .i_sel     (pix_idx),
        .o_clk     (o_pixel_clk)
    );

    dcls_clk_mux #(.N (5)) u_vr_mux (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_src     ({o_pixel_clk, prog_clk, s.mclk, q.mclk_half, s.second_video}),
        .i_sel     (vr_idx),
        .o_clk     (o_vr_clk)
    );

    dcls_clk_mux #(.N (5)) u_link_mux (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_src     ({1'b0, !q.vr_half, q.vr_half, !o_vr_clk, o_vr_clk}),
        .i_sel     (link_idx),
        .o_clk     (o_panel_link_clk)
    );

    dcls_clk_mux #(.N (2)) u_ref_mux (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_src     ({s.mclk, s.ext32k}),
        .i_sel     (q.c2.refresh_int),
        .o_clk     (o_refresh_clk)
    );

    // Shared blank or TV clock pin.
    dcls_clk_mux #(.N (2)) u_tv_mux (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_src     ({q.tv_cnt[1], i_blank}),
        .i_sel     (q.c2.tv_pin),
        .o_clk     (o_tv_blank_pin)
    );

    // ************************************************************
    // Registers, dividers and controls
    // ************************************************************
    always_comb begin
        d = q;
        if (i_port_index_wr) begin
            d.idx = i_port_wdata;
        end
        if (i_port_data_wr) begin
            case (q.idx)
                DCLS_IDX_PAL:  d.pal = dcls_pal_t'({i_port_wdata[7:2], 2'h0});
                DCLS_IDX_CLK1: d.c1  = dcls_clk1_t'(i_port_wdata);
                DCLS_IDX_CLK2: d.c2  = dcls_clk2_t'(i_port_wdata);
                default: ;
            endcase
        end
        if (i_port_data_rd) begin
            case (q.idx)
                DCLS_IDX_PAL:  d.rdata = q.pal;
                DCLS_IDX_CLK1: d.rdata = q.c1;
                DCLS_IDX_CLK2: d.rdata = q.c2;
                default:       d.rdata = 8'h00;
            endcase
        end
        d.synth_prev = s.synth;
        if (s.synth && !q.synth_prev) begin
            d.post_div = !q.post_div;
        end
        d.prog_prev = prog_clk;
        if (prog_clk && !q.prog_prev) begin
            d.tv_cnt = q.tv_cnt + 2'h1;
        end
        d.mclk_prev = s.mclk;
        if (s.mclk && !q.mclk_prev) begin
            d.mclk_half = !q.mclk_half;
        end
        d.vr_prev = o_vr_clk;
        if (o_vr_clk && !q.vr_prev) begin
            d.vr_half = !q.vr_half;
        end
        d.crt_on = !q.pal.power[0];
        d.lcd_on = !q.pal.power[1];
        // Write steering; code 11 writes nothing.
        d.crt_we = i_pal_write && !q.pal.target[0];
        d.lcd_we = i_pal_write && !q.pal.target[1];
        d.crt_8bit = |q.pal.width;
        d.gamma    = q.pal.width[0];
        d.force_8dot = q.c1.char8 && i_lcd_or_tv;
        d.pix_trim = dcls_trim_ns(q.c1.pix_trim);
        d.mem_trim = dcls_trim_ns(q.c1.mem_trim);
        d.test_direct    = q.c2.test_direct;
        d.refresh_active = low_power;
        d.lp_rate_en  = low_power && q.c2.refresh_int;
        d.lp_rate_sel = i_pd_freq_sel;
        // Sleep outranks standby; stopped syncs are held low.
        if (i_sleep) begin
            d.hsync = q.c2.sleep_sync ? 1'b0 : i_hsync;
            d.vsync = 1'b0;
        end else if (i_standby) begin
            d.hsync = 1'b0;
            d.vsync = i_vsync;
        end else begin
            d.hsync = i_hsync;
            d.vsync = i_vsync;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q     <= '0;
            q.pal <= DCLS_PAL_RST;
            q.c1  <= DCLS_CLK1_RST;
            q.c2  <= DCLS_CLK2_RST;
        end else begin
            q <= d;
        end
    end

    assign o_port_rdata     = q.rdata;
    assign o_crt_ram_on     = q.crt_on;
    assign o_lcd_ram_on     = q.lcd_on;
    assign o_crt_ram_we     = q.crt_we;
    assign o_lcd_ram_we     = q.lcd_we;
    assign o_crt_8bit       = q.crt_8bit;
    assign o_gamma_on       = q.gamma;
    assign o_force_8dot     = q.force_8dot;
    assign o_pix_trim_ns    = q.pix_trim;
    assign o_mem_trim_ns    = q.mem_trim;
    assign o_test_direct    = q.test_direct;
    assign o_refresh_active = q.refresh_active;
    assign o_lp_rate_en     = q.lp_rate_en;
    assign o_lp_rate_sel    = q.lp_rate_sel;
    assign o_hsync          = q.hsync;
    assign o_vsync          = q.vsync;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    a_pal_both_off: assert property (q.pal.power == 2'h3 |=> !o_crt_ram_on && !o_lcd_ram_on)
        else $error("Both palette RAMs should be stopped");
    a_write_crt_only: assert property (
        i_pal_write && q.pal.target == 2'h2 |=> o_crt_ram_we && !o_lcd_ram_we)
        else $error("CRT-only write steering wrong");
    a_gamma_width: assert property (q.pal.width[0] |=> o_gamma_on && o_crt_8bit)
        else $error("Gamma needs eight-bit entries");
    a_synth_pick: assert property (
        s.ext_en_n && q.c1.pix_src == DCLS_SRC_SYNTH |-> pix_idx == DCLS_PIX_SYNTH)
        else $error("Synthesizer not selected");
    a_ext_pick: assert property (!s.ext_en_n |-> pix_idx == DCLS_PIX_EXT)
        else $error("External clock pin not selected");
    a_legacy_slow: assert property (s.ext_en_n && q.c1.pix_src == DCLS_SRC_LEGACY
        && !q.c1.refresh_hi && !i_legacy_clk_sel[0] |-> pix_idx == DCLS_PIX_VGA25)
        else $error("Legacy 25 MHz source not selected");
    a_legacy_fast: assert property (s.ext_en_n && q.c1.pix_src == DCLS_SRC_LEGACY
        && q.c1.refresh_hi && !i_legacy_clk_sel[0] |-> pix_idx == DCLS_PIX_VGA31)
        else $error("Legacy 31.5 MHz source not selected");
    a_vr_pixel: assert property (!i_virtual_refresh_en |-> vr_idx == DCLS_VR_PIXEL)
        else $error("Refresh clock must follow pixel clock");
    a_sleep_sync: assert property (i_sleep && q.c2.sleep_sync |=> !o_hsync && !o_vsync)
        else $error("Sleep should stop both syncs");
    a_standby_sync: assert property (i_standby && !i_sleep |=> !o_hsync)
        else $error("Standby should stop horizontal sync");
    a_reset_vals: assert property (!$past(i_rst_n) |-> q.c1 == DCLS_CLK1_RST
        && q.c2 == DCLS_CLK2_RST && q.pal == DCLS_PAL_RST)
        else $error("Register reset values wrong");

    c_pix_switch: cover property ($changed(pix_idx) ##[1:64] $rose(o_pixel_clk));
    c_tv_clock:   cover property (q.c2.tv_pin ##[1:200] $rose(o_tv_blank_pin));
    c_link_half:  cover property (link_idx == 3'h2 ##[1:200] $rose(o_panel_link_clk));
    c_sleep:      cover property (i_sleep && !q.c2.sleep_sync ##1 o_hsync);

endmodule : dcls_clock_control
`default_nettype wire

//--- tb.sv
// Self-checking testbench for the display clock and palette control block.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import dcls_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic iw = 1'b0, dw = 1'b0, dr = 1'b0, pw = 1'b0, slp = 1'b0, stb = 1'b0, lcd = 1'b0;
    logic hin = 1'b1;
    logic vr, lnk;
    logic [7:0] wd = 8'h00;
    logic [1:0] pd = 2'h0;
    logic [3:0] hist;
    dcls_src_t src = 12'h800;
    logic [7:0] rdata;
    logic pix, crt_on, lcd_on, crt_we, lcd_we, c8, gam, f8, tdir, ract, lpen, ho, vo;
    logic signed [2:0] ptr, mtr;
    logic [1:0] lps;
    int fails = 0;
    int checks_done = 0;

    always #4 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) hist <= {hist[2:0], src.ext_clk};
    // The external clock toggles every four cycles, slow enough to be sampled.
    always begin
        repeat (4) @(posedge i_ref_clk);
        #1 src.ext_clk = ~src.ext_clk;
    end

    dcls_clock_control dcls_clock_control_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_port_index_wr(iw), .i_port_data_wr(dw), .i_port_data_rd(dr), .i_port_wdata(wd),
        .o_port_rdata(rdata), .i_src_pins(src), .i_legacy_clk_sel(2'h0),
        .i_synth_post_scale(1'b0), .i_virtual_refresh_en(1'b0), .i_lcd_or_tv(lcd),
        .i_sleep(slp), .i_standby(stb), .i_pd_freq_sel(pd), .i_pal_write(pw),
        .i_hsync(hin), .i_vsync(1'b1), .i_blank(1'b0), .o_pixel_clk(pix), .o_vr_clk(vr),
        .o_panel_link_clk(lnk), .o_refresh_clk(), .o_tv_blank_pin(), .o_crt_ram_on(crt_on),
        .o_lcd_ram_on(lcd_on), .o_crt_ram_we(crt_we), .o_lcd_ram_we(lcd_we), .o_crt_8bit(c8),
        .o_gamma_on(gam), .o_force_8dot(f8), .o_pix_trim_ns(ptr), .o_mem_trim_ns(mtr),
        .o_test_direct(tdir), .o_refresh_active(ract), .o_lp_rate_en(lpen),
        .o_lp_rate_sel(lps), .o_hsync(ho), .o_vsync(vo));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : tick

    task automatic put(input logic [7:0] idx, input logic [7:0] val);
        iw = 1'b1; wd = idx; tick(1);
        iw = 1'b0; dw = 1'b1; wd = val; tick(1);
        dw = 1'b0; tick(2);
    endtask : put

    task automatic get(input logic [7:0] idx, input logic [7:0] exp, input string what);
        iw = 1'b1; wd = idx; tick(1);
        iw = 1'b0; dr = 1'b1; tick(1);
        dr = 1'b0;
        chk(what, rdata, exp);
    endtask : get

    task automatic t_regs;
        get(DCLS_IDX_PAL, 8'h00, "pal");
        get(DCLS_IDX_CLK1, 8'hC0, "clk1");
        get(DCLS_IDX_CLK2, 8'h80, "clk2");
        get(8'h6A, 8'h00, "unmapped");
        put(DCLS_IDX_PAL, 8'hFF);
        get(DCLS_IDX_PAL, 8'hFC, "pal_rw");
    endtask : t_regs

    task automatic t_pal;
        for (int i = 0; i < 4; i++) begin
            put(DCLS_IDX_PAL, {i[1:0], i[1:0], i[1:0], 2'h0});
            chk("crt_on", crt_on, !i[0]);
            chk("lcd_on", lcd_on, !i[1]);
            chk("c8", c8, i != 0);
            chk("gam", gam, i[0]);
            pw = 1'b1; tick(1);
            pw = 1'b0;
            chk("crt_we", crt_we, !i[0]);
            chk("lcd_we", lcd_we, !i[1]);
            tick(1);
            chk("we_end", {crt_we, lcd_we}, 8'h00);
        end
    endtask : t_pal

    task automatic t_clk1;
        logic signed [2:0] t;
        for (int i = 0; i < 4; i++) begin
            lcd = i[1];
            put(DCLS_IDX_CLK1, {4'h1, i[1:0], i[1:0]} & {4'h2 | i[0], 4'hF});
            t = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : (i == 2) ? 3'h1 : 3'h2;
            chk("ptrim", ptr, t);
            chk("mtrim", mtr, t);
            chk("f8", f8, i[0] & i[1]);
        end
        // TV setup: fixed 14.318 MHz source, trims and override left clear.
        put(DCLS_IDX_CLK1, 8'hC0);
        get(DCLS_IDX_CLK1, 8'hC0, "tv_setup");
    endtask : t_clk1

    task automatic t_sleep;
        for (int i = 0; i < 4; i++) begin
            slp = (i == 1) || (i == 2);
            stb = (i == 3);
            pd = i[1:0];
            put(DCLS_IDX_CLK2, {1'b0, i[0], 2'h0, i[0], i == 2, 2'h0});
            chk("tdir", tdir, i[0]);
            chk("ract", ract, i != 0);
            chk("lpen", lpen, (i != 0) & i[0]);
            chk("lps", lps, i[1:0]);
            chk("hs", ho, i < 2);
            chk("vs", vo, (i == 0) || (i == 3));
            hin = 1'b0;
            tick(1);
            chk("hs_low", ho, 8'h00);
            hin = 1'b1;
            tick(1);
            chk("hs_high", ho, i < 2);
        end
        slp = 1'b0; stb = 1'b0;
    endtask : t_sleep

    task automatic t_ext;
        src.ext_en_n = 1'b0;
        tick(24);
        for (int k = 0; k < 16; k++) begin
            chk("pix_ext", pix, hist[2]);
            chk("vr_pix", vr, hist[3]);
            chk("link_off", lnk, 8'h00);
            tick(1);
        end
    endtask : t_ext

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run

    initial begin
        tick(6);
        i_rst_n = 1'b1;
        t_regs; t_pal; t_clk1; t_sleep; t_ext;
        complete_run;
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        tick(5000);
        fails++;
        complete_run;
    end
endmodule : tb
`default_nettype wire
